// ---- bench/cfg_eeprom_model.sv ----
`timescale 1ns/100ps
module cfg_eeprom_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rewind_i,
  input wire logic [7:0] image_i [20],
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  // --------
  // Byte source
  // --------
  int idx = 0;
  int seed = 97122;
  // Idle cycles show inverted junk so a stale byte never looks valid
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i || rewind_i) begin
      idx = 0;
      valid_o <= 1'b0;
      data_o <= 8'h00;
    end else if (!valid_o || ready_i) begin
      if (valid_o)
        idx = idx + 1;
      if (idx < 20 && $random(seed) % 3 != 0) begin
        valid_o <= 1'b1;
        data_o <= image_i[idx];
      end else begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
      end
    end
  end
endmodule : cfg_eeprom_model

// ---- bench/cfg_loader_assertions.sv ----
`timescale 1ns/100ps
module cfg_loader_assertions
  import cfg_loader_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic ROM_VALID_I,
  input wire logic [7:0] ROM_DATA_I,
  input wire logic ROM_READY_O,
  input wire logic LOAD_DONE_O,
  input wire logic LOAD_ERR_O
);
  // --------
  // Stream checks
  // --------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic [7:0] off_r;
  logic rs;
  logic tk;
  assign rs = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == A_CTRL
    && PSTRB_I[0] && PWDATA_I[CTRL_RESTART_BIT];
  // Restart wins over a byte taken in the same cycle
  assign tk = ROM_VALID_I && ROM_READY_O && !rs;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      off_r <= ROM_FIRST;
    end else if (rs) begin
      off_r <= ROM_FIRST;
    end else if (tk) begin
      off_r <= off_r + 8'h01;
    end
  end
  done_closes_a: assert property (LOAD_DONE_O |-> !ROM_READY_O)
    else $error("stream open after done");
  done_hold_a: assert property (LOAD_DONE_O && !rs |=> LOAD_DONE_O)
    else $error("done dropped");
  end_done_a: assert property (
    tk && off_r == ROM_END && ROM_DATA_I == END_MARK_VAL
    |=> LOAD_DONE_O && !LOAD_ERR_O) else $error("no done on end mark");
  end_err_a: assert property (
    tk && off_r == ROM_END && ROM_DATA_I != END_MARK_VAL
    |=> LOAD_ERR_O && !LOAD_DONE_O) else $error("bad end mark accepted");
  ind_err_a: assert property (
    tk && off_r == ROM_IND && ROM_DATA_I != FUNC_IND_VAL
    |=> LOAD_ERR_O ##1 !ROM_READY_O) else $error("bad indicator accepted");
  cnt_err_a: assert property (
    tk && off_r == ROM_CNT && ROM_DATA_I != REC_CNT_VAL
    |=> LOAD_ERR_O) else $error("bad count accepted");
  err_stops_a: assert property (LOAD_ERR_O |-> !ROM_READY_O)
    else $error("stream open after error");
  last_byte_a: assert property (tk |-> off_r <= ROM_END)
    else $error("byte taken past end");
  cover property ($rose(LOAD_DONE_O));
  cover property ($rose(LOAD_ERR_O));
  cover property (ROM_READY_O && !ROM_VALID_I);
endmodule : cfg_loader_assertions

// ---- bench/smart_card_cfg_eeprom_loader_test.sv ----
`timescale 1ns/100ps
module smart_card_cfg_eeprom_loader_test;
  import cfg_loader_pkg::*;
  // --------
  // Bench
  // --------
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, w;
  logic [3:0] strb = 4'hF;
  logic rdy, slverr, rv, rr, done, err, e, rew = 1'b0;
  logic [7:0] rd;
  logic [7:0] img [20];
  int failures = 0, total_checks = 0, seed = 97122;
  always #12.5 clk = ~clk;
  cfg_loader u_cfg_loader(.CLK_I(clk), .RST_I(rst), .PSEL_I(sel),
    .PENABLE_I(en), .PWRITE_I(wr), .PADDR_I(addr), .PWDATA_I(wdat),
    .PSTRB_I(strb), .PRDATA_O(rdat), .PREADY_O(rdy), .PSLVERR_O(slverr),
    .ROM_VALID_I(rv), .ROM_DATA_I(rd), .ROM_READY_O(rr),
    .LOAD_DONE_O(done), .LOAD_ERR_O(err));
  cfg_eeprom_model u_cfg_eeprom_model(.clk_i(clk), .rst_i(rst),
    .rewind_i(rew), .image_i(img), .ready_i(rr), .valid_o(rv), .data_o(rd));
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = rdat;
    e = slverr;
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(x, q);
  endtask : rdc
  // Fault kinds: 0 clean, 1 bad indicator, 2 bad count, 3 bad end mark
  task automatic run(input int k);
    logic [31:0] g, s, x;
    logic [7:0] o;
    for (int i = 0; i < 20; i++) img[i] = 8'($random(seed));
    img[3] = (k == 1) ? 8'h05 : FUNC_IND_VAL;
    img[4] = (k == 2) ? 8'h0D : REC_CNT_VAL;
    img[19] = (k == 3) ? 8'h00 : END_MARK_VAL;
    g = $random(seed);
    s = $random(seed);
    apb(1'b1, A_GCTL, g);
    apb(1'b1, A_SC1, s);
    rew <= 1'b1;
    @(posedge clk);
    rew <= 1'b0;
    apb(1'b1, A_CTRL, 32'h3);
    for (int i = 0; i < 300 && done !== 1'b1 && err !== 1'b1; i++)
      @(posedge clk);
    chk(k == 0, done);
    chk(k != 0, err);
    o = (k == 1) ? ROM_CNT : (k == 2) ? ROM_CLASS0 : ROM_END + 8'h01;
    apb(1'b0, A_STATUS, 32'h0);
    chk(k == 0 ? 1 : k == 3 ? 4 : 2, q[2:0]);
    chk(o, q[31:24]);
    chk(k == 0 ? ST_DONE : ST_FAIL, q[23:16]);
    rdc(A_CTRL, 32'h1);
    for (int n = 0; n < 4; n++) begin
      x[8*n +: 8] = (s[8*n +: 8] & ~(n == 3 ? SC1_HI_MASK : SC1_LO_MASK))
        | (img[13+n] & (n == 3 ? SC1_HI_MASK : SC1_LO_MASK));
    end
    if (k == 1 || k == 2) begin
      rdc(A_GCTL, {24'h0, g[7:0]});
    end else begin
      rdc(A_CLASS, {8'h00, img[7], img[6], img[5]});
      rdc(A_SUBSYS, {img[11], img[10], img[9], img[8]});
      rdc(A_GCTL, {24'h0, img[12][7:4], g[3:0]});
      rdc(A_SC1, x);
      rdc(A_SC2, {16'h0, img[18], img[17]});
    end
    $display("test %0d ended", k);
  endtask : run
  initial begin
    for (int i = 0; i < 20; i++) img[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(0, rr);
    for (int a = 8; a <= 24; a += 4) rdc(a[7:0], CFG_RST);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(1, e);
    rdc(8'h1C, 32'h0);
    chk(1, e);
    w = $random(seed);
    strb <= 4'h5;
    apb(1'b1, A_SUBSYS, w);
    strb <= 4'hF;
    rdc(A_SUBSYS, w & 32'h00FF_00FF);
    $display("register test ended");
    for (int k = 0; k < 4; k++) run(k);
    run(0);
    print_verdict();
  end
  // Five loads of about 30 cycles each; far more means a hang
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : smart_card_cfg_eeprom_loader_test
bind cfg_loader cfg_loader_assertions u_cfg_loader_assertions(.*);

// ---- rtl/cfg_loader.sv ----
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps

// Function
// - bytes 4Eh..50h are reserved slot current, never loaded
// - byte 51h must hold 04h, the smart card function indicator
// - byte 52h holds record byte count, 0Eh for smart card
// - bytes 53h..55h go to class code bytes 09h..0Bh
// - bytes 56h,57h go to subsystem vendor ID, low byte first
// - bytes 58h,59h go to subsystem ID, low byte first
// - byte 5Ah updates only general control bits 7..4
// - bytes 5Bh..5Dh write only bits 4 and 0 of config 1 bytes 0..2
// - byte 5Eh writes only bits 7..4 and 0 of config 1 byte 3
// - bytes 5Fh,60h copied whole into config 2 bytes 0,1
module cfg_loader
  import cfg_loader_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic ROM_VALID_I,
  input wire logic [7:0] ROM_DATA_I,
  output logic ROM_READY_O,
  output logic LOAD_DONE_O,
  output logic LOAD_ERR_O
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  function automatic logic [7:0] lane(input logic [7:0] old_v,
                                      input int idx);
    lane = PSTRB_I[idx] ? PWDATA_I[idx*8 +: 8] : old_v;
  endfunction : lane

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ld_state_type state_r;
  logic [7:0] offset_r;
  logic [7:0] remain_r;
  logic en_r;
  logic done_r;
  logic err_rec_r;
  logic err_end_r;
  logic [23:0] class_r;
  logic [31:0] subsys_r;
  logic [7:0] gctl_r;
  logic [31:0] sc1_r;
  logic [15:0] sc2_r;
  logic take;
  logic apb_wr;
  logic apb_rd;
  logic restart;
  logic hit;
  logic ld_wr;
  logic sw_wr;
  ld_stat_type stat;

  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  // Read data latched in setup so it stands through the access phase
  assign apb_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign restart = apb_wr & (PADDR_I == A_CTRL) & PSTRB_I[0]
                   & PWDATA_I[CTRL_RESTART_BIT];
  // Loader only draws bytes while enabled and in the skip, indicator, count, data or end state
  assign ROM_READY_O = en_r & (state_r inside {ST_SKIP, ST_IND, ST_CNT,
                                               ST_DATA, ST_END});
  assign take = ROM_READY_O & ROM_VALID_I;
  assign LOAD_DONE_O = done_r;
  assign LOAD_ERR_O = err_rec_r | err_end_r;

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_r <= 1'b0;
    end else if (apb_wr && PADDR_I == A_CTRL && PSTRB_I[0]) begin
      en_r <= PWDATA_I[CTRL_EN_BIT];
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      offset_r <= ROM_FIRST;
      remain_r <= 8'h00;
      done_r <= 1'b0;
      err_rec_r <= 1'b0;
      err_end_r <= 1'b0;
    end else if (restart) begin
      state_r <= ST_IDLE;
      offset_r <= ROM_FIRST;
      remain_r <= 8'h00;
      done_r <= 1'b0;
      err_rec_r <= 1'b0;
      err_end_r <= 1'b0;
    end else begin
      if (take) begin
        offset_r <= offset_r + 8'h01;
      end
      unique case (state_r)
        ST_IDLE: begin
          if (en_r) begin
            state_r <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          // Slot current bytes pass without any load
          if (take && offset_r == ROM_RSV_LAST) begin
            state_r <= ST_IND;
          end
        end
        ST_IND: begin
          if (take) begin
            // Wrong indicator: nothing of this record is trusted
            if (ROM_DATA_I == FUNC_IND_VAL) begin
              state_r <= ST_CNT;
            end else begin
              state_r <= ST_FAIL;
              err_rec_r <= 1'b1;
            end
          end
        end
        ST_CNT: begin
          if (take) begin
            if (ROM_DATA_I == REC_CNT_VAL) begin
              remain_r <= REC_CNT_VAL;
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_FAIL;
              err_rec_r <= 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (take) begin
            remain_r <= remain_r - 8'h01;
            if (remain_r == 8'h01) begin
              state_r <= ST_END;
            end
          end
        end
        ST_END: begin
          if (take) begin
            if (ROM_DATA_I == END_MARK_VAL) begin
              state_r <= ST_DONE;
              done_r <= 1'b1;
            end else begin
              state_r <= ST_FAIL;
              err_end_r <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        ST_FAIL: begin
          state_r <= ST_FAIL;
        end
        default: begin
          state_r <= ST_FAIL;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Loader write wins over a software write in the same cycle
  assign ld_wr = take & (state_r == ST_DATA);
  assign sw_wr = apb_wr & ~ld_wr;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      class_r <= CFG_RST[23:0];
    end else if (ld_wr) begin
      unique case (offset_r)
        ROM_CLASS0: class_r[7:0] <= ROM_DATA_I;
        ROM_CLASS1: class_r[15:8] <= ROM_DATA_I;
        ROM_CLASS2: class_r[23:16] <= ROM_DATA_I;
        default: class_r <= class_r;
      endcase
    end else if (sw_wr && PADDR_I == A_CLASS) begin
      class_r <= {lane(class_r[23:16], 2), lane(class_r[15:8], 1),
                  lane(class_r[7:0], 0)};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      subsys_r <= CFG_RST;
    end else if (ld_wr) begin
      unique case (offset_r)
        ROM_SVID0: subsys_r[7:0] <= ROM_DATA_I;
        ROM_SVID1: subsys_r[15:8] <= ROM_DATA_I;
        ROM_SSID0: subsys_r[23:16] <= ROM_DATA_I;
        ROM_SSID1: subsys_r[31:24] <= ROM_DATA_I;
        default: subsys_r <= subsys_r;
      endcase
    end else if (sw_wr && PADDR_I == A_SUBSYS) begin
      subsys_r <= {lane(subsys_r[31:24], 3), lane(subsys_r[23:16], 2),
                   lane(subsys_r[15:8], 1), lane(subsys_r[7:0], 0)};
    end
  end

  // Lower nibble stays software owned across a load
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gctl_r <= CFG_RST[7:0];
    end else if (ld_wr && offset_r == ROM_GCTL) begin
      gctl_r <= merge(gctl_r, ROM_DATA_I, GCTL_MASK);
    end else if (sw_wr && PADDR_I == A_GCTL) begin
      gctl_r <= lane(gctl_r, 0);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sc1_r <= CFG_RST;
    end else if (ld_wr) begin
      unique case (offset_r)
        ROM_SC1B0: begin
          sc1_r[7:0] <= merge(sc1_r[7:0], ROM_DATA_I, SC1_LO_MASK);
        end
        ROM_SC1B1: begin
          sc1_r[15:8] <= merge(sc1_r[15:8], ROM_DATA_I,
                               SC1_LO_MASK);
        end
        ROM_SC1B2: begin
          sc1_r[23:16] <= merge(sc1_r[23:16], ROM_DATA_I,
                                SC1_LO_MASK);
        end
        ROM_SC1B3: begin
          sc1_r[31:24] <= merge(sc1_r[31:24], ROM_DATA_I,
                                SC1_HI_MASK);
        end
        default: sc1_r <= sc1_r;
      endcase
    end else if (sw_wr && PADDR_I == A_SC1) begin
      sc1_r <= {lane(sc1_r[31:24], 3), lane(sc1_r[23:16], 2),
                lane(sc1_r[15:8], 1), lane(sc1_r[7:0], 0)};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sc2_r <= CFG_RST[15:0];
    end else if (ld_wr) begin
      unique case (offset_r)
        ROM_SC2B0: sc2_r[7:0] <= ROM_DATA_I;
        ROM_SC2B1: sc2_r[15:8] <= ROM_DATA_I;
        default: sc2_r <= sc2_r;
      endcase
    end else if (sw_wr && PADDR_I == A_SC2) begin
      sc2_r <= {lane(sc2_r[15:8], 1), lane(sc2_r[7:0], 0)};
    end
  end

  // ------------------------------------------------------------
  // APB read side
  // ------------------------------------------------------------
  always_comb begin
    stat = '0;
    stat.offset = offset_r;
    stat.state = state_r;
    stat.err_end = err_end_r;
    stat.err_rec = err_rec_r;
    stat.done = done_r;
  end

  assign hit = (PADDR_I inside {A_CTRL, A_STATUS, A_CLASS, A_SUBSYS,
                                A_GCTL, A_SC1, A_SC2});
  // Zero wait states; unmapped words answer with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (apb_rd) begin
      unique case (PADDR_I)
        A_CTRL: PRDATA_O <= {31'h0000_0000, en_r};
        A_STATUS: PRDATA_O <= stat;
        A_CLASS: PRDATA_O <= {8'h00, class_r};
        A_SUBSYS: PRDATA_O <= subsys_r;
        A_GCTL: PRDATA_O <= {24'h00_0000, gctl_r};
        A_SC1: PRDATA_O <= sc1_r;
        A_SC2: PRDATA_O <= {16'h0000, sc2_r};
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

endmodule : cfg_loader

// ---- rtl/cfg_loader_pkg.sv ----
package cfg_loader_pkg;

  // ------------------------------------------------------------
  // Memory stream offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ROM_FIRST = 8'h4E;
  localparam logic [7:0] ROM_RSV_LAST = 8'h50;
  localparam logic [7:0] ROM_IND = 8'h51;
  localparam logic [7:0] ROM_CNT = 8'h52;
  localparam logic [7:0] ROM_CLASS0 = 8'h53;
  localparam logic [7:0] ROM_CLASS1 = 8'h54;
  localparam logic [7:0] ROM_CLASS2 = 8'h55;
  localparam logic [7:0] ROM_SVID0 = 8'h56;
  localparam logic [7:0] ROM_SVID1 = 8'h57;
  localparam logic [7:0] ROM_SSID0 = 8'h58;
  localparam logic [7:0] ROM_SSID1 = 8'h59;
  localparam logic [7:0] ROM_GCTL = 8'h5A;
  localparam logic [7:0] ROM_SC1B0 = 8'h5B;
  localparam logic [7:0] ROM_SC1B1 = 8'h5C;
  localparam logic [7:0] ROM_SC1B2 = 8'h5D;
  localparam logic [7:0] ROM_SC1B3 = 8'h5E;
  localparam logic [7:0] ROM_SC2B0 = 8'h5F;
  localparam logic [7:0] ROM_SC2B1 = 8'h60;
  localparam logic [7:0] ROM_END = 8'h61;

  // ------------------------------------------------------------
  // Record values and field masks
  // ------------------------------------------------------------
  localparam logic [7:0] FUNC_IND_VAL = 8'h04;
  localparam logic [7:0] REC_CNT_VAL = 8'h0E;
  localparam logic [7:0] END_MARK_VAL = 8'h80;
  localparam logic [7:0] GCTL_MASK = 8'hF0;
  localparam logic [7:0] SC1_LO_MASK = 8'h11;
  localparam logic [7:0] SC1_HI_MASK = 8'hF1;

  // ------------------------------------------------------------
  // APB map and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CLASS = 8'h08;
  localparam logic [7:0] A_SUBSYS = 8'h0C;
  localparam logic [7:0] A_GCTL = 8'h10;
  localparam logic [7:0] A_SC1 = 8'h14;
  localparam logic [7:0] A_SC2 = 8'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SKIP = 8'h02,
    ST_IND = 8'h04,
    ST_CNT = 8'h08,
    ST_DATA = 8'h10,
    ST_END = 8'h20,
    ST_DONE = 8'h40,
    ST_FAIL = 8'h80
  } ld_state_type;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] state;
    logic [12:0] pad;
    logic err_end;
    logic err_rec;
    logic done;
  } ld_stat_type;

endpackage : cfg_loader_pkg
